/* rtl/fcb_pkg.sv */
/*
 * fcb_pkg: constants, command codes, phases and bus timing for the
 * flash command bus host sequencer.
 * assumes: core clock of CLK_MHZ, one byte-wide parallel flash on the pins.
 */
package fcb_pkg;

	localparam int unsigned CLK_MHZ = 250;          // core clock rate

	// command bytes written into the device command register
	localparam logic [7:0] CMD_SET_READ  = 8'h00;
	localparam logic [7:0] CMD_SIGNATURE = 8'h90;
	localparam logic [7:0] CMD_ERASE     = 8'h20;
	localparam logic [7:0] CMD_ERASE_VFY = 8'ha0;
	localparam logic [7:0] CMD_PROGRAM   = 8'h40;
	localparam logic [7:0] CMD_PROG_VFY  = 8'hc0;
	localparam logic [7:0] CMD_RESET     = 8'hff;
	localparam logic [7:0] ERASED_BYTE   = 8'hff;   // verify value after erase
	localparam logic [7:0] PREPROG_BYTE  = 8'h00;   // value written before erase
	localparam logic [15:0] LAST_ADDR    = 16'hffff; // top of 64K array

	// pin timing, all minimum figures in ns
	localparam longint unsigned T_VPP_SETUP_NS = 100;     // supply setup to enable
	localparam longint unsigned T_WE_LOW_NS    = 40;      // write enable pulse
	localparam longint unsigned T_WE_HIGH_NS   = 110;     // rest of 150 ns write cycle
	localparam longint unsigned T_ACCESS_NS    = 150;     // read access time
	localparam longint unsigned T_FLOAT_NS     = 35;      // output turn-off time
	localparam longint unsigned T_PROGRAM_NS   = 10000;   // program_pulse_time
	localparam longint unsigned T_ERASE_NS     = 9500000; // erase_pulse_time
	localparam longint unsigned T_RECOVERY_NS  = 6000;    // write_to_read_recovery

	// cycle counts, least times rounded up
	localparam int unsigned VPP_CYC  = int'((T_VPP_SETUP_NS * CLK_MHZ + 999) / 1000);
	localparam int unsigned WL_CYC   = int'((T_WE_LOW_NS * CLK_MHZ + 999) / 1000);
	localparam int unsigned WH_CYC   = int'((T_WE_HIGH_NS * CLK_MHZ + 999) / 1000);
	localparam int unsigned ACC_CYC  = int'((T_ACCESS_NS * CLK_MHZ + 999) / 1000);
	localparam int unsigned FLT_CYC  = int'((T_FLOAT_NS * CLK_MHZ + 999) / 1000);
	localparam int unsigned PGM_CYC  = int'((T_PROGRAM_NS * CLK_MHZ + 999) / 1000);
	localparam int unsigned ERS_CYC  = int'((T_ERASE_NS * CLK_MHZ + 999) / 1000);
	localparam int unsigned REC_CYC  = int'((T_RECOVERY_NS * CLK_MHZ + 999) / 1000);

	localparam int unsigned PROGRAM_TRIES = 25;    // retry ceiling per byte
	localparam int unsigned ERASE_TRIES   = 1000;  // erase pulse ceiling

	// user operations
	typedef enum logic [2:0] {
		OP_READ,
		OP_SIGNATURE,
		OP_PROGRAM,
		OP_ERASE,
		OP_ABORT
	} fcb_op_t;

	// pin-level activity
	typedef enum logic [2:0] {
		B_IDLE, B_STEP, B_WLOW, B_WHIGH, B_RLOW, B_RHIGH, B_WAIT
	} fcb_bus_t;

	// algorithm phases
	typedef enum logic [4:0] {
		P_SETREAD, P_READ, P_SIGCMD, P_SIGREAD,
		P_PG1, P_PG2, P_PGW, P_PV, P_PVW, P_PVR, P_PVC,
		P_ER1, P_ER2, P_ERW, P_EV, P_EVW, P_EVR, P_EVC,
		P_AB1, P_AB2, P_FIN
	} fcb_phase_t;

	// what a phase starts on the pins
	typedef enum logic [1:0] {L_NONE, L_WR, L_RD, L_WAIT} fcb_launch_t;

endpackage : fcb_pkg

/* rtl/fcb_host.sv */
/*
 * fcb_host: host sequencer driving a command-register parallel flash.
 * runs read, signature read, byte program with verify loop, chip erase
 * (preprogram, erase pulses, erase verify) and abort on the device pins.
 * assumes: device pins sampled synchronous to i_core_clk, external glue
 * turns o_program_supply_high into the high program supply level.
 */
// Notes on behaviour
// - read only with enables low, write high
// - write set-read before reads with supply high
// - erase verify write carries address, then read
// - program is 40h then address and data
// - program verify C0h then read latched byte
// - wait recovery time before any read
// - at most 25 program tries per byte
// - preprogram every byte to 00h first
// - erase needs two 20h writes
`timescale 1ns/10ps
module fcb_host
	import fcb_pkg::*;
#(
	parameter int unsigned ERASE_CYCLES  = ERS_CYC,        // erase wait, shortenable
	parameter int unsigned PROG_TRIES    = PROGRAM_TRIES,  // program retry ceiling
	parameter int unsigned ERS_TRIES     = ERASE_TRIES     // erase pulse ceiling
) (
	input  wire logic        i_core_clk,              // core clock
	input  wire logic        i_rst_b,                 // synchronous reset, low
	input  wire logic        i_req_valid,             // operation request
	output logic             o_req_ready,             // sequencer idle
	input  wire fcb_op_t     i_req_op,                // operation kind
	input  wire logic [15:0] i_req_addr,              // byte address
	input  wire logic [7:0]  i_req_data,              // byte to program
	input  wire logic        i_abort,                 // abort a pulse wait
	output logic             o_done,                  // one-cycle completion
	output logic             o_ok,                    // result of last operation
	output logic [7:0]       o_rdata,                 // byte from last read
	output logic             o_program_supply_high,   // raise program supply
	output logic             o_ce_b,                  // chip enable, low
	output logic             o_oe_b,                  // output enable, low
	output logic             o_we_b,                  // write enable, low
	output logic [15:0]      o_addr,                  // address pins
	output logic [7:0]       o_dq_out,                // data pins, driven value
	output logic             o_dq_oe_b,               // data drive enable, low
	input  wire logic [7:0]  i_dq_in                  // data pins, sensed value
);

	// counter must hold the program pulse too when the erase wait is shortened
	localparam int unsigned LONG_CYC = (ERASE_CYCLES > PGM_CYC) ? ERASE_CYCLES : PGM_CYC;
	localparam int unsigned CNT_W = $clog2(LONG_CYC + 1);  // longest wait
	localparam int unsigned TRY_W = $clog2(ERS_TRIES + PROG_TRIES + 1);

	// complete sequencer state
	typedef struct packed {
		fcb_bus_t         bus;      // pin activity
		fcb_phase_t       phase;    // algorithm step
		logic [CNT_W-1:0] cnt;      // cycle down-counter
		logic [15:0]      addr;     // address on pins
		logic [7:0]       wdata;    // byte on pins during writes
		logic [7:0]       tdata;    // expected verify byte
		logic [7:0]       rdata;    // last sampled byte
		logic [TRY_W-1:0] tries;    // pulses spent on this byte, or on the whole erase
		logic             preprog;  // erase in preprogram pass
		logic             rec_wait; // recovery wait owed before a plain read
		logic             supply;   // program supply request
		logic             ce_b;
		logic             oe_b;
		logic             we_b;
		logic             dq_oe_b;
		logic             done;
		logic             ok;
	} fcb_state_t;

	fcb_state_t st;                  // registered state
	fcb_state_t next_st;             // next state
	fcb_launch_t launch;             // pin action started this cycle
	logic [7:0]  launch_byte;        // byte for a started write
	logic [CNT_W-1:0] launch_wait;   // length of a started wait

	// handshake is combinational from the idle state
	assign o_req_ready = (st.bus == B_IDLE);

	// next-state logic
	always_comb begin
		next_st     = st;
		next_st.done = 1'b0;
		launch      = L_NONE;
		launch_byte = st.wdata;
		launch_wait = '0;
		unique case (st.bus)
			// accept a request, raise supply, wait its setup time
			B_IDLE: begin
				if (i_req_valid) begin
					next_st.supply  = 1'b1;
					next_st.addr    = i_req_addr;
					next_st.tdata   = i_req_data;
					next_st.tries   = '0;
					next_st.preprog = 1'b0;
					next_st.rec_wait = 1'b0;
					next_st.ok      = 1'b0;
					next_st.bus     = B_WAIT;
					next_st.cnt     = CNT_W'(VPP_CYC - 1);
					unique case (i_req_op)
						OP_READ:      next_st.phase = P_SETREAD;
						OP_SIGNATURE: next_st.phase = P_SIGCMD;
						OP_PROGRAM:   next_st.phase = P_PG1;
						OP_ERASE: begin
							// preprogram pass over the whole array first
							next_st.phase   = P_PG1;
							next_st.preprog = 1'b1;
							next_st.addr    = '0;
							next_st.tdata   = PREPROG_BYTE;
						end
						OP_ABORT:     next_st.phase = P_AB1;
						default:      next_st.phase = P_FIN;        // illegal op code
					endcase
				end
			end
			// decide the next algorithm step
			B_STEP: begin
				unique case (st.phase)
					P_SETREAD: begin
						launch_byte   = CMD_SET_READ;
						launch        = L_WR;
						next_st.rec_wait = 1'b1;
						next_st.phase = P_READ;
					end
					P_READ, P_SIGREAD: begin
						if (st.rec_wait) begin
							// command write just ended, let the device recover
							launch_wait      = CNT_W'(REC_CYC - 1);
							launch           = L_WAIT;
							next_st.rec_wait = 1'b0;
						end else begin
							launch        = L_RD;
							next_st.ok    = 1'b1;
							next_st.phase = P_FIN;
						end
					end
					P_SIGCMD: begin
						launch_byte   = CMD_SIGNATURE;
						launch        = L_WR;
						next_st.rec_wait = 1'b1;
						next_st.phase = P_SIGREAD;
					end
					P_PG1: begin
						launch_byte   = CMD_PROGRAM;
						launch        = L_WR;
						next_st.phase = P_PG2;
					end
					P_PG2: begin
						// address and data held through the whole write
						launch_byte   = st.tdata;
						launch        = L_WR;
						next_st.tries = st.tries + TRY_W'(1);
						next_st.phase = P_PGW;
					end
					P_PGW: begin
						launch_wait   = CNT_W'(PGM_CYC - 1);
						launch        = L_WAIT;
						next_st.phase = P_PV;
					end
					P_PV: begin
						// this write edge also ends the program pulse
						launch_byte   = CMD_PROG_VFY;
						launch        = L_WR;
						next_st.phase = P_PVW;
					end
					P_PVW, P_EVW: begin
						launch_wait   = CNT_W'(REC_CYC - 1);
						launch        = L_WAIT;
						next_st.phase = (st.phase == P_PVW) ? P_PVR : P_EVR;
					end
					P_PVR: begin
						launch        = L_RD;
						next_st.phase = P_PVC;
					end
					P_PVC: begin
						if (st.rdata == st.tdata) begin
							next_st.tries = '0;
							if (!st.preprog) begin
								next_st.ok    = 1'b1;
								next_st.phase = P_FIN;
							end else if (st.addr == LAST_ADDR) begin
								next_st.preprog = 1'b0;
								next_st.addr    = '0;
								next_st.phase   = P_ER1;
							end else begin
								next_st.addr  = st.addr + 16'h0001;
								next_st.phase = P_PG1;
							end
						end else if (st.tries >= TRY_W'(PROG_TRIES)) begin
							next_st.phase = P_FIN;
						end else begin
							next_st.phase = P_PG1;
						end
					end
					P_ER1: begin
						launch_byte   = CMD_ERASE;
						launch        = L_WR;
						next_st.phase = P_ER2;
					end
					P_ER2: begin
						launch_byte   = CMD_ERASE;
						launch        = L_WR;
						next_st.tries = st.tries + TRY_W'(1);
						next_st.phase = P_ERW;
					end
					P_ERW: begin
						launch_wait   = CNT_W'(ERASE_CYCLES - 1);
						launch        = L_WAIT;
						next_st.phase = P_EV;
					end
					P_EV: begin
						// carries the address to check, ends the erase pulse
						launch_byte   = CMD_ERASE_VFY;
						launch        = L_WR;
						next_st.phase = P_EVW;
					end
					P_EVR: begin
						launch        = L_RD;
						next_st.phase = P_EVC;
					end
					P_EVC: begin
						if (st.rdata == ERASED_BYTE) begin
							if (st.addr == LAST_ADDR) begin
								next_st.ok    = 1'b1;
								next_st.phase = P_FIN;
							end else begin
								next_st.addr  = st.addr + 16'h0001;
								next_st.phase = P_EV;
							end
						end else if (st.tries >= TRY_W'(ERS_TRIES)) begin
							next_st.phase = P_FIN;
						end else begin
							next_st.phase = P_ER1;
						end
					end
					P_AB1: begin
						launch_byte   = CMD_RESET;
						launch        = L_WR;
						next_st.phase = P_AB2;
					end
					P_AB2: begin
						launch_byte   = CMD_RESET;
						launch        = L_WR;
						next_st.ok    = 1'b1;
						next_st.phase = P_FIN;
					end
					P_FIN: begin
						next_st.done   = 1'b1;
						next_st.supply = 1'b0;
						next_st.bus    = B_IDLE;
					end
					default: next_st.phase = P_FIN;
				endcase
			end
			// write enable low: device takes address on the falling edge
			B_WLOW: begin
				if (st.cnt == '0) begin
					next_st.we_b = 1'b1;
					next_st.cnt  = CNT_W'(WH_CYC - 1);
					next_st.bus  = B_WHIGH;
				end else begin
					next_st.cnt = st.cnt - CNT_W'(1);
				end
			end
			// write enable high: data held past the rising edge
			B_WHIGH: begin
				if (st.cnt == '0) begin
					next_st.ce_b    = 1'b1;
					next_st.dq_oe_b = 1'b1;
					next_st.bus     = B_STEP;
				end else begin
					next_st.cnt = st.cnt - CNT_W'(1);
				end
			end
			// output enable low: sample at end of access time
			B_RLOW: begin
				if (st.cnt == '0) begin
					next_st.rdata = i_dq_in;
					next_st.oe_b  = 1'b1;
					next_st.ce_b  = 1'b1;
					next_st.cnt   = CNT_W'(FLT_CYC - 1);
					next_st.bus   = B_RHIGH;
				end else begin
					next_st.cnt = st.cnt - CNT_W'(1);
				end
			end
			// let the device float its outputs before we drive again
			B_RHIGH: begin
				if (st.cnt == '0)
					next_st.bus = B_STEP;
				else
					next_st.cnt = st.cnt - CNT_W'(1);
			end
			// timed wait; abort cuts a pulse short
			B_WAIT: begin
				if (i_abort && st.phase != P_AB1 && st.phase != P_AB2
						&& st.phase != P_FIN) begin
					next_st.phase = P_AB1;
					next_st.bus   = B_STEP;
				end else if (st.cnt == '0) begin
					next_st.bus = B_STEP;
				end else begin
					next_st.cnt = st.cnt - CNT_W'(1);
				end
			end
			default: next_st.bus = B_IDLE;
		endcase
		// start the chosen pin action
		unique case (launch)
			L_WR: begin
				next_st.wdata   = launch_byte;
				next_st.ce_b    = 1'b0;
				next_st.oe_b    = 1'b1;
				next_st.we_b    = 1'b0;
				next_st.dq_oe_b = 1'b0;
				next_st.cnt     = CNT_W'(WL_CYC - 1);
				next_st.bus     = B_WLOW;
			end
			L_RD: begin
				next_st.ce_b    = 1'b0;
				next_st.oe_b    = 1'b0;
				next_st.we_b    = 1'b1;
				next_st.dq_oe_b = 1'b1;
				next_st.cnt     = CNT_W'(ACC_CYC - 1);
				next_st.bus     = B_RLOW;
			end
			L_WAIT: begin
				next_st.cnt = launch_wait;
				next_st.bus = B_WAIT;
			end
			L_NONE: ;
		endcase
	end

	// state register; device assumed in read mode after power-up
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_b) begin
			st         <= '0;
			st.bus     <= B_IDLE;
			st.phase   <= P_FIN;
			st.ce_b    <= 1'b1;
			st.oe_b    <= 1'b1;
			st.we_b    <= 1'b1;
			st.dq_oe_b <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// outputs straight from state flip-flops
	assign o_done                = st.done;
	assign o_ok                  = st.ok;
	assign o_rdata               = st.rdata;
	assign o_program_supply_high = st.supply;
	assign o_ce_b                = st.ce_b;
	assign o_oe_b                = st.oe_b;
	assign o_we_b                = st.we_b;
	assign o_addr                = st.addr;
	assign o_dq_out              = st.wdata;
	assign o_dq_oe_b             = st.dq_oe_b;

endmodule : fcb_host

/* tb/fcb_host_props.sv */
/* fcb_host_props: pin protocol checks for the flash host sequencer.
   assumes: bound to fcb_host, one clock domain, reset low. */
`timescale 1ns/10ps
module fcb_props
	import fcb_pkg::*;
#(
	parameter int unsigned PROG_TRIES = PROGRAM_TRIES  // retry ceiling
) (
	input  wire logic        i_core_clk,
	input  wire logic        i_rst_b,
	input  wire logic        i_req_valid,
	input  wire logic        o_req_ready,
	input  wire logic        o_program_supply_high,
	input  wire logic        o_ce_b,
	input  wire logic        o_oe_b,
	input  wire logic        o_we_b,
	input  wire logic [15:0] o_addr,
	input  wire logic [7:0]  o_dq_out,
	input  wire logic        o_dq_oe_b
);
	logic        we_q;       // write strobe one cycle back
	logic [15:0] sup_cnt;    // cycles with supply raised
	logic [15:0] rec_cnt;    // cycles since last write strobe rise
	logic [15:0] last_pa;    // address of last program data write
	logic [7:0]  last_cmd;   // byte of last write
	logic [7:0]  pair_code;  // first byte of an open pair
	logic        pair_open;  // first of a two-write command seen
	logic [5:0]  tries;      // program pulses on one byte
	wire we_rise = o_we_b && !we_q;

	// free-running history, saturating counters
	always_ff @(posedge i_core_clk) begin
		we_q <= o_we_b;
		if (!o_program_supply_high) sup_cnt <= 16'h0;
		else if (sup_cnt != 16'hffff) sup_cnt <= sup_cnt + 16'h1;
		if (we_rise) rec_cnt <= 16'h0;
		else if (rec_cnt != 16'hffff) rec_cnt <= rec_cnt + 16'h1;
	end

	// command pairing and per-byte retry count
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_b || (i_req_valid && o_req_ready)) begin
			pair_open <= 1'b0;
			tries     <= 6'h0;
			last_cmd  <= 8'h00;
			last_pa   <= 16'h0;
		end else if (we_rise) begin
			last_cmd  <= o_dq_out;
			pair_code <= o_dq_out;
			pair_open <= !pair_open && last_cmd != CMD_PROGRAM
				&& (o_dq_out == CMD_ERASE || o_dq_out == CMD_RESET);
			if (last_cmd == CMD_PROGRAM) begin
				tries   <= (o_addr == last_pa) ? tries + 6'h1 : 6'h1;
				last_pa <= o_addr;
			end
		end
	end

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_b);

	a_read_enables: assert property (!o_oe_b |-> !o_ce_b && o_we_b && o_dq_oe_b)
		else $error("read strobe without chip enable or during write");
	a_write_enables: assert property (!o_we_b |-> !o_ce_b && o_oe_b && !o_dq_oe_b)
		else $error("write strobe without chip enable or data drive");
	a_write_supply: assert property (!o_we_b |-> o_program_supply_high)
		else $error("write strobe with supply low");
	a_supply_setup: assert property ($fell(o_ce_b) |-> sup_cnt >= VPP_CYC)
		else $error("chip enable too soon after supply rise");
	a_we_width: assert property ($fell(o_we_b) |=> !o_we_b [*8])
		else $error("write strobe pulse too short");
	a_addr_latch: assert property (!o_we_b && !$fell(o_we_b) |-> $stable(o_addr))
		else $error("address moved during write strobe");
	a_data_hold: assert property ($rose(o_we_b) |-> (!o_dq_oe_b && $stable(o_dq_out)) [*3])
		else $error("data released at write strobe rise");
	a_verify_wait: assert property ($fell(o_oe_b) && (last_cmd == CMD_PROG_VFY
		|| last_cmd == CMD_ERASE_VFY) |-> rec_cnt >= REC_CYC)
		else $error("verify read before recovery time");
	a_read_recovery: assert property ($fell(o_oe_b) |-> rec_cnt >= REC_CYC)
		else $error("read started before recovery time");
	a_pair_second: assert property (we_rise && pair_open |-> o_dq_out == pair_code)
		else $error("two-write command not repeated");
	a_try_limit: assert property (tries <= PROG_TRIES)
		else $error("too many program pulses on one byte");

	c_retry: cover property (tries == 6'h2);
	c_abort: cover property (we_rise && pair_open && pair_code == CMD_RESET);
	c_verify: cover property ($fell(o_oe_b) && last_cmd == CMD_PROG_VFY);
endmodule : fcb_props

bind fcb_host fcb_props #(.PROG_TRIES(PROG_TRIES)) i_props (.i_core_clk, .i_rst_b,
	.i_req_valid, .o_req_ready, .o_program_supply_high, .o_ce_b, .o_oe_b, .o_we_b,
	.o_addr, .o_dq_out, .o_dq_oe_b);

/* tb/fcb_flash_model.sv */
/* fcb_flash_model: behavioural command-register flash, 64K bytes.
   assumes: pins sampled on the host clock, no pull on the data lines. */
`timescale 1ns/10ps
module fcb_flash_model
	import fcb_pkg::*;
#(
	parameter logic [7:0] MFG_CODE = 8'h5c,  // arbitrary maker code
	parameter logic [7:0] DEV_CODE = 8'ha7   // arbitrary part code
) (
	input  wire logic        i_core_clk,
	input  wire logic        i_supply_high,
	input  wire logic        i_ce_b,
	input  wire logic        i_oe_b,
	input  wire logic        i_we_b,
	input  wire logic [15:0] i_addr,
	input  wire logic [7:0]  i_dq,
	input  wire logic        i_slow,   // each byte needs two pulses
	output logic      [7:0]  o_dq
);
	logic [7:0]  mem [65536];          // array contents
	logic [7:0]  cmd = CMD_SET_READ;   // powers up in read mode
	logic [15:0] wlat, plat, elat;     // strobe, program, verify latches
	logic        we_q = 1'b1;          // strobe history
	logic        pend = 1'b0;          // program data write expected
	logic        tried = 1'b0;         // first slow pulse spent
	logic [7:0]  rd;                   // byte to present
	logic [7:0]  last = 8'h00;         // last byte driven
	wire reading = !i_ce_b && !i_oe_b && i_we_b;

	// fill with an address pattern
	initial begin
		for (int i = 0; i < 65536; i++) mem[i] = 8'(i) ^ 8'(i >> 8) ^ 8'h5a;
	end

	// byte selected by mode
	always_comb begin
		if (!i_supply_high) rd = mem[i_addr];
		else case (cmd)
			CMD_SIGNATURE: rd = (i_addr == 16'h0) ? MFG_CODE : DEV_CODE;
			CMD_ERASE_VFY: rd = mem[elat];
			CMD_PROG_VFY: rd = mem[plat];
			default: rd = mem[i_addr];
		endcase
	end
	assign o_dq = reading ? rd : ~last;  // released lines drift

	// command register on write strobe edges
	always @(posedge i_core_clk) begin
		we_q <= i_we_b;
		if (reading) last <= rd;
		if (!i_we_b && we_q) wlat <= i_addr;
		if (i_we_b && !we_q && !i_ce_b && i_oe_b && i_supply_high) begin
			if (pend) begin
				pend <= 1'b0;
				plat <= wlat;
				tried <= i_slow && !tried;
				if (!i_slow || tried) mem[wlat] <= mem[wlat] & i_dq;
			end else begin
				pend <= (i_dq == CMD_PROGRAM);
				cmd <= i_dq;
				if (i_dq == CMD_ERASE_VFY) elat <= wlat;
				if (i_dq == CMD_RESET && cmd == CMD_RESET) cmd <= CMD_SET_READ;
				if (i_dq == CMD_ERASE && cmd == CMD_ERASE) begin
					cmd <= CMD_SET_READ;
					for (int i = 0; i < 65536; i++) mem[i] <= 8'hff;
				end
			end
		end
	end
endmodule : fcb_flash_model

/* tb/fcb_host_bench.sv */
/* fcb_host_bench: self-checking bench for the flash host sequencer.
   assumes: flash model on the pins, expectations queued per request. */
`timescale 1ns/10ps
module fcb_host_bench
	import fcb_pkg::*;
;
	localparam logic [7:0] MFG = 8'h5c;  // arbitrary maker code
	localparam logic [7:0] DEV = 8'ha7;  // arbitrary part code
	typedef struct packed {
		logic       ok;   // expected result flag
		logic       chk;  // read byte is meaningful
		logic [7:0] rd;   // expected read byte
	} fcb_note_t;
	logic        i_core_clk = 1'b0;
	logic        i_rst_b = 1'b0;
	logic        i_req_valid = 1'b0;
	fcb_op_t     i_req_op = OP_READ;
	logic [15:0] i_req_addr = 16'h0;
	logic [7:0]  i_req_data = 8'h0;
	logic        i_abort = 1'b0;
	logic        slow = 1'b0;   // model programs on second pulse
	logic        o_req_ready, o_done, o_ok, o_program_supply_high;
	logic        o_ce_b, o_oe_b, o_we_b, o_dq_oe_b, rdy_n;
	logic [15:0] o_addr, a;
	logic [7:0]  o_rdata, o_dq_out, dev_dq, i_dq_in, d;
	fcb_note_t   notes [$];     // expected results, oldest first
	fcb_note_t   nt;
	int          error_cnt = 0;
	int          check_count = 0;
	int          seed = 41529;
	assign i_dq_in = o_dq_oe_b ? dev_dq : o_dq_out;  // wire level

	fcb_host #(.ERASE_CYCLES(50), .ERS_TRIES(4)) i_dut (.i_core_clk, .i_rst_b, .i_req_valid,
		.o_req_ready, .i_req_op, .i_req_addr, .i_req_data, .i_abort, .o_done, .o_ok, .o_rdata,
		.o_program_supply_high, .o_ce_b, .o_oe_b, .o_we_b, .o_addr, .o_dq_out, .o_dq_oe_b,
		.i_dq_in);
	fcb_flash_model #(.MFG_CODE(MFG), .DEV_CODE(DEV)) i_flash (.i_core_clk,
		.i_supply_high(o_program_supply_high), .i_ce_b(o_ce_b), .i_oe_b(o_oe_b),
		.i_we_b(o_we_b), .i_addr(o_addr), .i_dq(o_dq_out), .i_slow(slow), .o_dq(dev_dq));

	// clock, 4 ns period
	initial begin
		forever #2 i_core_clk = ~i_core_clk;
	end

	function automatic logic [7:0] pat(input logic [15:0] ad);
		return ad[7:0] ^ ad[15:8] ^ 8'h5a;
	endfunction : pat

	task automatic chk_flag(input string what, input logic exp, input logic got);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %b seen %b", what, exp, got);
		end
	endtask : chk_flag

	task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_val

	task automatic close_out();
		if (error_cnt == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : close_out

	// queue the note, hold the request until taken
	task automatic run(input fcb_op_t op, input logic [15:0] ad, input logic [7:0] dt,
		input logic ok, input logic chk, input logic [7:0] rd);
		int n;
		notes.push_back('{ok, chk, rd});
		n = 0;
		i_req_op    <= op;
		i_req_addr  <= ad;
		i_req_data  <= dt;
		i_req_valid <= 1'b1;
		do begin
			@(posedge i_core_clk);
			n++;
		end while (!rdy_n && n < 100000);
		i_req_valid <= 1'b0;
		@(posedge i_core_clk);
	endtask : run

	// ready as seen by the next rising edge
	always @(negedge i_core_clk) rdy_n <= o_req_ready;

	// compare each completion with the oldest note
	always @(negedge i_core_clk) begin
		if (o_done === 1'b1) begin
			if (notes.size() == 0) chk_flag("spare done", 1'b0, 1'b1);
			else begin
				nt = notes.pop_front();
				chk_flag("o_ok", nt.ok, o_ok);
				if (nt.chk) chk_val("o_rdata", {8'h0, nt.rd}, {8'h0, o_rdata});
			end
		end
	end

	// main sequence
	initial begin
		repeat (5) @(posedge i_core_clk);
		@(negedge i_core_clk);
		chk_val("enables", 16'h7, {13'h0, o_ce_b, o_oe_b, o_we_b});
		chk_flag("dq drive", 1'b1, o_dq_oe_b);
		chk_flag("supply", 1'b0, o_program_supply_high);
		@(posedge i_core_clk);
		i_rst_b <= 1'b1;
		@(posedge i_core_clk);
		for (int k = 0; k < 4; k++) begin  // corners and random addresses
			a = (k == 0) ? 16'h0000 : (k == 1) ? LAST_ADDR : 16'($random(seed));
			run(OP_READ, a, 8'h00, 1'b1, 1'b1, pat(a));
		end
		run(OP_SIGNATURE, 16'h0000, 8'h00, 1'b1, 1'b1, MFG);
		run(OP_SIGNATURE, 16'h0001, 8'h00, 1'b1, 1'b1, DEV);
		for (int k = 0; k < 2; k++) begin  // prompt then slow programming
			a = 16'($random(seed));
			d = pat(a) & 8'($random(seed));
			slow <= (k == 1);
			run(OP_PROGRAM, a, d, 1'b1, 1'b1, d);
			run(OP_READ, a, 8'h00, 1'b1, 1'b1, d);
		end
		slow <= 1'b0;  // preprogram must land on its first pulse
		run(OP_ERASE, 16'h0, 8'h00, 1'b1, 1'b0, 8'h00);
		repeat (400) @(posedge i_core_clk);
		i_abort <= 1'b1;
		while (!rdy_n) @(posedge i_core_clk);
		i_abort <= 1'b0;
		run(OP_READ, 16'h0, 8'h00, 1'b1, 1'b1, PREPROG_BYTE);
		run(OP_ABORT, 16'h0, 8'h00, 1'b1, 1'b0, 8'h00);
		run(fcb_op_t'(3'd7), 16'h0, 8'h00, 1'b0, 1'b0, 8'h00);
		run(OP_READ, LAST_ADDR, 8'h00, 1'b1, 1'b1, pat(LAST_ADDR));
		while (notes.size() != 0) @(posedge i_core_clk);
		repeat (4) @(posedge i_core_clk);
		close_out();
	end

	// cut a hang short
	initial begin
		#240000;
		error_cnt++;
		close_out();
	end
endmodule : fcb_host_bench
